// ==== core/amcs_pkg.sv ====
// package for the converter timing control: pin codes, ratios, settling counts
// assumes a single master clock domain; no register bus
package amcs_pkg;
	// profile select codes
	localparam logic [1:0] PROF_HIGH_SPEED = 2'h0;
	localparam logic [1:0] PROF_HIGH_RES = 2'h1;
	localparam logic [1:0] PROF_LOW_POWER = 2'h2;
	localparam logic [1:0] PROF_LOW_SPEED = 2'h3;
	// format select boundaries
	localparam logic [2:0] FMT_FRAME_FIRST = 3'h3;
	localparam logic [2:0] FMT_MODULATOR = 3'h6;
	// clock-to-rate ratios
	localparam int RATIO_256 = 256;
	localparam int RATIO_512 = 512;
	localparam int RATIO_2560 = 2560;
	localparam int RATIO_W = 12;
	// settling, in conversion periods
	localparam int SETTLE_SPI = 129;
	localparam int SETTLE_FRAME = 128;
	localparam int SETTLE_W = 8;
	// master clock limits, in kHz, kept for reference by the host side
	localparam int MIN_CLK_KHZ = 100;
	localparam int MAX_CLK_HS_KHZ = 32768;
	localparam int MAX_CLK_HR_KHZ = 27000;

	typedef enum logic [1:0] {
		AMCS_PROTO_SPI,
		AMCS_PROTO_FRAME,
		AMCS_PROTO_MOD
	} amcs_proto_type;

	typedef struct packed {
		logic [1:0] profile;
		logic clock_divide_select;
	} amcs_cfg_type;
endpackage

// ==== core/amcs_rate_div.sv ====
// conversion-period divider: one-cycle pulse every ratio master clocks
// assumes clear comes from logic on the same clock
`timescale 1ns/100ps
module amcs_rate_div #(
	parameter int W = 12
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic clear,
	input wire logic [W-1:0] ratio,
	output logic conv_pulse
);
	logic [W-1:0] count;

	always_ff @(posedge mclk) begin
		if (!rst_n || clear) begin
			count <= '0;
			conv_pulse <= 1'b0;
		end else if (count >= ratio - W'(1)) begin
			count <= '0;
			conv_pulse <= 1'b1;
		end else begin
			count <= count + W'(1);
			conv_pulse <= 1'b0;
		end
	end
endmodule

// ==== core/amcs_control.sv ====
// conversion timing control: profile and ratio selection, filter restart,
// data-valid gating for the spi and frame-sync protocols
// assumes mode, divider, format and restart pins are asynchronous to mclk,
// sclk is oversampled on mclk; serial shifting lives outside this block
`timescale 1ns/100ps

// How it works
// - one master clock drives all eight channels
// - profile pins pick speed, resolution, power, slow
// - profile pins watched continuously, no restart needed
// - high-speed 256, high-resolution 512 clocks per word
// - low-power 512/256, low-speed 2560/512 by divider
// - word rate scales with master clock frequency
// - spi: ready held high after change, 129 max
// - frame-sync: outputs low after change, 127-128
// - restart low halts and clears filter counters
// - restart high resumes conversion aligned to release
// - restart sampled on master clock edges
// - spi: ready goes high on restart low
// - spi: ready falls after settling, 129 max
// - frame-sync: outputs low through restart and settling
// - format pins pick spi, frame-sync or modulator
// - spi: ready returns high on first sclk fall
module amcs_control #(
	parameter int SETTLE_SPI = amcs_pkg::SETTLE_SPI,
	parameter int SETTLE_FRAME = amcs_pkg::SETTLE_FRAME
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [1:0] profile_select,
	input wire logic clock_divide_select,
	input wire logic [2:0] format_select,
	input wire logic restart_n,
	input wire logic sclk,
	output logic data_ready_n,
	output logic result_valid,
	output logic conv_strobe,
	output logic filter_clear,
	output logic [1:0] profile,
	output logic [amcs_pkg::RATIO_W-1:0] ratio,
	output amcs_pkg::amcs_proto_type protocol
);
	// ************************************************************
	// pin synchronisers
	// ************************************************************
	amcs_pkg::amcs_cfg_type cfg_meta;
	amcs_pkg::amcs_cfg_type cfg_sync;
	amcs_pkg::amcs_cfg_type cfg_last;
	logic [2:0] fmt_meta;
	logic [2:0] fmt_sync;
	logic restart_meta;
	logic restart_sync;
	logic sclk_meta;
	logic sclk_sync;
	logic sclk_last;

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			cfg_meta <= '0;
			cfg_sync <= '0;
			fmt_meta <= 3'h0;
			fmt_sync <= 3'h0;
			restart_meta <= 1'b1;
			restart_sync <= 1'b1;
			sclk_meta <= 1'b0;
			sclk_sync <= 1'b0;
			sclk_last <= 1'b0;
		end else begin
			cfg_meta <= '{profile: profile_select, clock_divide_select: clock_divide_select};
			cfg_sync <= cfg_meta;
			fmt_meta <= format_select;
			fmt_sync <= fmt_meta;
			restart_meta <= restart_n;
			restart_sync <= restart_meta;
			sclk_meta <= sclk;
			sclk_sync <= sclk_meta;
			sclk_last <= sclk_sync;
		end
	end

	// ************************************************************
	// profile, ratio and protocol decode
	// ************************************************************
	logic [amcs_pkg::RATIO_W-1:0] next_ratio;
	amcs_pkg::amcs_proto_type next_protocol;
	logic cfg_change;
	logic sclk_fall;

	always_comb begin
		unique case (cfg_sync.profile)
			amcs_pkg::PROF_HIGH_SPEED: next_ratio = amcs_pkg::RATIO_W'(amcs_pkg::RATIO_256);
			amcs_pkg::PROF_HIGH_RES: next_ratio = amcs_pkg::RATIO_W'(amcs_pkg::RATIO_512);
			amcs_pkg::PROF_LOW_POWER: next_ratio = cfg_sync.clock_divide_select ?
				amcs_pkg::RATIO_W'(amcs_pkg::RATIO_512) :
				amcs_pkg::RATIO_W'(amcs_pkg::RATIO_256);
			amcs_pkg::PROF_LOW_SPEED: next_ratio = cfg_sync.clock_divide_select ?
				amcs_pkg::RATIO_W'(amcs_pkg::RATIO_2560) :
				amcs_pkg::RATIO_W'(amcs_pkg::RATIO_512);
		endcase
		if (fmt_sync >= amcs_pkg::FMT_MODULATOR) begin
			next_protocol = amcs_pkg::AMCS_PROTO_MOD;
		end else if (fmt_sync >= amcs_pkg::FMT_FRAME_FIRST) begin
			next_protocol = amcs_pkg::AMCS_PROTO_FRAME;
		end else begin
			next_protocol = amcs_pkg::AMCS_PROTO_SPI;
		end
	end

	// profile changes are acted on at any time, no reset needed
	assign cfg_change = (cfg_sync != cfg_last);
	assign sclk_fall = sclk_last && !sclk_sync;

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			cfg_last <= '0;
			profile <= amcs_pkg::PROF_HIGH_SPEED;
			ratio <= amcs_pkg::RATIO_W'(amcs_pkg::RATIO_256);
			protocol <= amcs_pkg::AMCS_PROTO_SPI;
		end else begin
			cfg_last <= cfg_sync;
			profile <= cfg_sync.profile;
			ratio <= next_ratio;
			protocol <= next_protocol;
		end
	end

	// ************************************************************
	// filter restart and conversion timing
	// ************************************************************
	// held clear while restart is low or a config change lands; the divider
	// then restarts from zero on release, so every device shares the edge
	logic clear_now;
	logic conv_pulse;

	assign clear_now = !restart_sync || cfg_change;

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			filter_clear <= 1'b1;
		end else begin
			filter_clear <= clear_now;
		end
	end

	// all channels take the same strobe from the one master clock
	amcs_rate_div #(
		.W(amcs_pkg::RATIO_W)
	) u_div (
		.mclk(mclk),
		.rst_n(rst_n),
		.clear(clear_now),
		.ratio(next_ratio),
		.conv_pulse(conv_pulse)
	);

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			conv_strobe <= 1'b0;
		end else begin
			conv_strobe <= conv_pulse && !clear_now;
		end
	end

	// ************************************************************
	// settling counter and valid gating
	// ************************************************************
	logic [amcs_pkg::SETTLE_W-1:0] settle_count;
	logic settled;
	logic [amcs_pkg::SETTLE_W-1:0] settle_target;

	// frame-sync needs one period less; ready stays high in that mode, only result_valid waits on it
	assign settle_target = (next_protocol == amcs_pkg::AMCS_PROTO_FRAME) ?
		amcs_pkg::SETTLE_W'(SETTLE_FRAME) : amcs_pkg::SETTLE_W'(SETTLE_SPI);

	always_ff @(posedge mclk) begin
		if (!rst_n || clear_now) begin
			settle_count <= '0;
			settled <= 1'b0;
		end else if (conv_pulse && !settled) begin
			settle_count <= settle_count + amcs_pkg::SETTLE_W'(1);
			if (settle_count + amcs_pkg::SETTLE_W'(1) >= settle_target) begin
				settled <= 1'b1;
			end
		end
	end

	// ************************************************************
	// data-ready and result gating outputs
	// ************************************************************
	// ready falls on each settled conversion, rises on sclk fall; the word that
	// completes settling already counts, otherwise the fall comes one period late
	logic settle_hit;

	assign settle_hit = conv_pulse &&
		(settled || settle_count + amcs_pkg::SETTLE_W'(1) >= settle_target);

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			data_ready_n <= 1'b1;
		end else if (clear_now || next_protocol != amcs_pkg::AMCS_PROTO_SPI) begin
			data_ready_n <= 1'b1;
		end else if (settle_hit) begin
			data_ready_n <= 1'b0;
		end else if (sclk_fall || !settled) begin
			data_ready_n <= 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			result_valid <= 1'b0;
		end else begin
			result_valid <= settled && !clear_now;
		end
	end
endmodule

// ==== verif/amcs_control_chk.sv ====
// checker for the conversion timing control, ports only
// bound to every amcs_control instance; one clock domain
`timescale 1ns/100ps
module amcs_control_chk #(
	parameter int SETTLE_SPI = 129,
	parameter int SETTLE_FRAME = 128
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [1:0] profile_select,
	input wire logic clock_divide_select,
	input wire logic [2:0] format_select,
	input wire logic restart_n,
	input wire logic sclk,
	input wire logic data_ready_n,
	input wire logic result_valid,
	input wire logic conv_strobe,
	input wire logic filter_clear,
	input wire logic [1:0] profile,
	input wire logic [amcs_pkg::RATIO_W-1:0] ratio,
	input wire amcs_pkg::amcs_proto_type protocol
);
	// ****
	// helper state: pin stability, strobe spacing, strobes since clear
	// ****
	logic [5:0] pins;
	logic [2:0] cnt;
	logic [11:0] gap, exp_r;
	logic [7:0] ns;
	logic seen;
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	always_ff @(posedge mclk) begin
		pins <= {profile_select, clock_divide_select, format_select};
		if (!rst_n || pins != {profile_select, clock_divide_select, format_select})
			cnt <= 3'h0;
		else if (cnt != 3'h7)
			cnt <= cnt + 3'h1;
	end
	// hs and hr with divider 0 are left undefined, so they are not checked
	always_comb begin
		case (pins[5:3])
			3'h1, 3'h4: exp_r = 12'h100;
			3'h3, 3'h5, 3'h6: exp_r = 12'h200;
			3'h7: exp_r = 12'ha00;
			default: exp_r = 12'h0;
		endcase
	end
	// spacing is only judged once pins settled, since a change may restart the divider
	always_ff @(posedge mclk) begin
		gap <= conv_strobe ? 12'h0 : gap + 12'h1;
		if (!rst_n || filter_clear || cnt < 3'h5)
			seen <= 1'b0;
		else if (conv_strobe)
			seen <= 1'b1;
		if (!rst_n || filter_clear)
			ns <= 8'h0;
		else if (conv_strobe && ns != 8'hff)
			ns <= ns + 8'h1;
	end
	AST_CLR: assert property (!restart_n [*3] |=> filter_clear)
		else $error("filter not cleared while restart held");
	AST_RDY_SYNC: assert property (!restart_n [*3] |=> data_ready_n)
		else $error("ready low while restart held");
	AST_FS_SYNC: assert property (!restart_n [*3] |=> !result_valid)
		else $error("results not forced low while restart held");
	AST_HALT: assert property (filter_clear [*3] |-> !conv_strobe)
		else $error("conversion ran while filter cleared");
	AST_PROFILE: assert property (cnt > 3'h5 |-> profile == pins[5:4])
		else $error("profile does not follow pins");
	AST_RATIO: assert property (cnt > 3'h5 && exp_r != 12'h0 |-> ratio == exp_r)
		else $error("ratio wrong for profile and divider");
	AST_PROTO: assert property (cnt > 3'h5 |-> protocol ==
		(pins[2:0] < 3'h3 ? 2'h0 : pins[2:0] < 3'h6 ? 2'h1 : 2'h2))
		else $error("protocol wrong for format");
	AST_GAP: assert property (conv_strobe && seen |-> gap == ratio - 12'h1)
		else $error("conversion spacing differs from ratio");
	AST_SPI_SETTLE: assert property ($fell(data_ready_n) |->
		ns >= SETTLE_SPI - 1 && protocol == amcs_pkg::AMCS_PROTO_SPI)
		else $error("ready fell before settling");
	AST_FS_SETTLE: assert property ($rose(result_valid) |-> ns >= SETTLE_FRAME - 1)
		else $error("results released before settling");
	AST_SCLK: assert property (!data_ready_n && $fell(sclk) |-> ##[1:4] data_ready_n)
		else $error("ready not returned high after shift clock fall");
endmodule
bind amcs_control amcs_control_chk #(.SETTLE_SPI(SETTLE_SPI), .SETTLE_FRAME(SETTLE_FRAME)) u_chk (
	.mclk(mclk), .rst_n(rst_n), .profile_select(profile_select),
	.clock_divide_select(clock_divide_select), .format_select(format_select),
	.restart_n(restart_n), .sclk(sclk), .data_ready_n(data_ready_n),
	.result_valid(result_valid), .conv_strobe(conv_strobe), .filter_clear(filter_clear),
	.profile(profile), .ratio(ratio), .protocol(protocol));

// ==== verif/amcs_host_model.sv ====
// host-side model: shift clock for result readback
// assumes the bench enables it only while reading
`timescale 1ns/100ps
module amcs_host_model (
	input wire logic mclk,
	input wire logic run,
	output logic sclk
);
	logic [1:0] div = 2'h0;
	logic s = 1'b0;
	assign sclk = s;
	// mclk/4 stop-clock readback: held low between reads, never glitching;
	// updated on the rising edge so the bench's falling-edge run change never races it
	always @(posedge mclk) begin
		div <= run ? div + 2'h1 : 2'h0;
		s <= run & div[1];
	end
endmodule

// ==== verif/amcs_control_tb_top.sv ====
// self-checking bench for the conversion timing control
// assumes settling counts cut to S; host model supplies sclk
`timescale 1ns/100ps
module amcs_control_tb_top;
	localparam int S = 4;
	logic mclk = 1'b0, rst_n = 1'b0, cdiv = 1'b1, rst_pin = 1'b1, run = 1'b0;
	logic [1:0] psel = 2'h0, prof;
	logic [2:0] fsel = 3'h0;
	logic rdy_n, valid, strobe, clr, sclk;
	logic [11:0] ratio;
	amcs_pkg::amcs_proto_type proto;
	int miscompares = 0, samples_checked = 0, seed = 22703, k;
	always #5 mclk = ~mclk; // period is notional: the logic counts clocks only
	amcs_control #(.SETTLE_SPI(S), .SETTLE_FRAME(S)) DUT (.mclk(mclk), .rst_n(rst_n),
		.profile_select(psel), .clock_divide_select(cdiv), .format_select(fsel),
		.restart_n(rst_pin), .sclk(sclk), .data_ready_n(rdy_n), .result_valid(valid),
		.conv_strobe(strobe), .filter_clear(clr), .profile(prof), .ratio(ratio),
		.protocol(proto));
	amcs_host_model u_host (.mclk(mclk), .run(run), .sclk(sclk));
	// ****
	// tasks
	// ****
	task automatic chk(input logic [11:0] got, input logic [11:0] exp);
		samples_checked++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic end_sim;
		$display("checked %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic cyc(input int c);
		repeat (c) @(negedge mclk);
	endtask
	function automatic int m_ratio(input int p, input int d);
		int t[8] = '{0, 256, 0, 512, 256, 512, 512, 2560};
		return t[p * 2 + d];
	endfunction
	// held four clocks: the pin passes a two-stage synchroniser first
	task automatic pulse;
		rst_pin = 1'b0;
		cyc(4);
		chk({clr, rdy_n, valid}, 3'h6);
		rst_pin = 1'b1;
	endtask
	// counts strobes until data is declared valid; r=0 skips first-strobe timing
	task automatic settle(input logic frame, input int r);
		int n = 0, c = 0, first = 0;
		while ((frame ? !valid : rdy_n) && c < 20000) begin
			@(negedge mclk);
			n += strobe;
			c++;
			if (strobe && n == 1)
				first = c;
		end
		chk(12'(c < 20000), 12'h1);
		chk(12'(n), 12'(S));
		if (r != 0)
			chk(12'(first >= r && first <= r + 5), 12'h1);
	endtask
	// ****
	// tests
	// ****
	initial begin
		cyc(3);
		chk({clr, rdy_n, valid, strobe}, 12'hc);
		rst_n = 1'b1;
		for (int i = 0; i < 12; i++) begin
			k = i < 8 ? i : $random(seed);
			{psel, cdiv} = k[2:0];
			fsel = i < 8 ? k[2:0] : k[5:3];
			cyc(8);
			chk(prof, psel);
			if (m_ratio(psel, cdiv) != 0)
				chk(ratio, 12'(m_ratio(psel, cdiv)));
			chk(proto, 12'(fsel < 3 ? 0 : fsel < 6 ? 1 : 2));
		end
		$display("decode test done");
		{psel, cdiv, fsel} = 6'h08;
		cyc(8);
		pulse();
		settle(1'b0, 256);
		{psel, cdiv} = 3'h4;
		cyc(6);
		chk(rdy_n, 1'b1);
		settle(1'b0, 0);
		pulse();
		settle(1'b0, 256);
		run = 1'b1;
		cyc(12);
		chk(rdy_n, 1'b1);
		run = 1'b0;
		$display("spi test done");
		{psel, cdiv, fsel} = 6'h3c;
		run = 1'b1;
		cyc(8);
		pulse();
		settle(1'b1, 2560);
		chk(rdy_n, 1'b1);
		$display("frame test done");
		end_sim();
	end
	// the tests need about 14k clocks; allow twice that
	initial begin
		#300000;
		miscompares++;
		end_sim();
	end
endmodule
